// >>> src_defs.vh
`ifndef SRC_DEFS_VH
`define SRC_DEFS_VH
// opcodes
`define SRC_OP_CLOCK_READ    8'h13
`define SRC_OP_CLOCK_WRITE   8'h12
`define SRC_OP_SET_LATCH     8'h06
`define SRC_OP_CLEAR_LATCH   8'h04
`define SRC_OP_SAVE          8'h3C
`define SRC_OP_RELOAD        8'h60
`define SRC_OP_AUTO_ON       8'h59
`define SRC_OP_AUTO_OFF      8'h19
// clock register space and write fifo
`define SRC_NUM_CLOCK_REGS   16
`define SRC_CLOCK_ADDR_W     4
`define SRC_FLAGS_ADDR       4'h0
`define SRC_FLAGS_SNAP_BIT   1
`define SRC_FLAGS_TSET_BIT   0
`define SRC_FLAGS_RESET      8'h00
`define SRC_FIFO_DEPTH       16
`define SRC_FIFO_AW          4
`endif

// >>> src_fifo.v
`timescale 1ns/100ps
module src_fifo #(
   parameter WIDTH = 12,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             core_clk_in,
   input  wire             reset_in,
   input  wire             clk_en_in,
   input  wire             wr_valid_in,
   output wire             wr_ready_out,
   input  wire [WIDTH-1:0] wr_data_in,
   output wire             rd_valid_out,
   input  wire             rd_ready_in,
   output wire [WIDTH-1:0] rd_data_out
);
   reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
   reg [AW:0]      wr_ptr_reg;
   reg [AW:0]      rd_ptr_reg;
   wire            full;
   wire            empty;
   assign empty = (wr_ptr_reg == rd_ptr_reg);
   assign full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                  (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
   assign wr_ready_out = ~full;
   assign rd_valid_out = ~empty;
   assign rd_data_out  = mem_reg[rd_ptr_reg[AW-1:0]];
   always @(posedge core_clk_in) begin
      if (reset_in) begin
         wr_ptr_reg <= {(AW+1){1'b0}};
         rd_ptr_reg <= {(AW+1){1'b0}};
      end else if (clk_en_in) begin
         if (wr_valid_in && !full) begin
            mem_reg[wr_ptr_reg[AW-1:0]] <= wr_data_in;
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (rd_ready_in && !empty)
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
   end
endmodule // src_fifo

// >>> src_spi_clock_nv.v
`timescale 1ns/100ps
`include "src_defs.vh"
// Functional notes
// - sixteen clock registers, single or burst access.
// - read: opcode, 8-bit address, then addressed byte out; later SI ignored.
// - burst read increments address, wraps 0x0F to 0x00.
// - burst write stores at next address, wraps 0x0F to 0x00.
// - clock write accepted only with write latch set.
// - write: opcode, address, one or more data bytes stored.
// - non-flag registers writable only while time-set bit is one.
// - counters load new time only when time-set bit clears.
// - write latch cleared when a clock write completes.
// - save and reload opcodes decoded as listed patterns.
// - auto-save on and off opcodes decoded as listed patterns.
// - save starts whenever the write latch is set, whether or not anything was written.
// - reload command starts a software reload.
// - auto-save on command enables it; setting volatile.
// - auto-save enabled by default; off command disables it.
// - pause low with clock low freezes sequence, ignores SI, floats SO.
// - pause high with clock low resumes; clock toggles ignored meanwhile.
// - writes without latch ignored; back to standby at select release.
// - set-latch command sets latch; latch zero after reset.
// - output bytes shift on falling clock edge, MSB first.
// - snapshot-lock and time-set bits live in flags register at 0x00.
module src_spi_clock_nv #(
   parameter FIFO_DEPTH = `SRC_FIFO_DEPTH,
   parameter FIFO_AW    = `SRC_FIFO_AW
) (
   input  wire       core_clk_in,
   input  wire       reset_in,
   input  wire       clk_en_in,
   input  wire       sel_n_in,
   input  wire       sck_in,
   input  wire       si_in,
   input  wire       pause_n_in,
   output reg        so_out,
   output wire       so_oe_n_out,
   input  wire       nv_busy_in,
   output reg        save_req_out,
   output reg        reload_req_out,
   output reg        auto_save_en_out,
   output reg        write_latch_out,
   output reg        time_load_out,
   output reg        snapshot_lock_out,
   output reg        time_set_out,
   output wire       wr_valid_out,
   input  wire       wr_ready_in,
   output wire [3:0] wr_addr_out,
   output wire [7:0] wr_data_out,
   output wire       fifo_full_out
);
   localparam ST_OPCODE  = 3'h0;
   localparam ST_ADDR    = 3'h1;
   localparam ST_RDATA   = 3'h2;
   localparam ST_WDATA   = 3'h3;
   localparam ST_IGNORE  = 3'h4;
   localparam ST_SPECIAL = 3'h5;

   reg [2:0]  sel_sync_reg;
   reg [2:0]  sck_sync_reg;
   reg [1:0]  si_sync_reg;
   reg [1:0]  pause_sync_reg;
   reg        paused_reg;
   reg [2:0]  state_reg;
   reg [2:0]  bit_cnt_reg;
   reg [7:0]  shift_reg;
   reg [7:0]  opcode_reg;
   reg [3:0]  addr_reg;
   reg [7:0]  out_reg;
   reg        wrote_reg;
   reg [7:0]  clock_regs [0:`SRC_NUM_CLOCK_REGS-1];
   reg [7:0]  rd_byte_reg;
   wire       sel_act;
   wire       sel_rise;
   wire       sel_fall;
   wire       sck_rise;
   wire       sck_fall;
   wire       sck_low;
   wire [7:0] byte_in;
   wire       byte_done;
   wire       fifo_ready;
   wire       fifo_push;
   wire       fifo_out_valid;
   wire [11:0] fifo_out_data;
   wire       reg_wr_ok;

   assign sel_act  = ~sel_sync_reg[1];
   assign sel_fall = sel_sync_reg[2] & ~sel_sync_reg[1];
   assign sel_rise = ~sel_sync_reg[2] & sel_sync_reg[1];
   assign sck_rise = ~sck_sync_reg[2] & sck_sync_reg[1];
   assign sck_fall = sck_sync_reg[2] & ~sck_sync_reg[1];
   assign sck_low  = ~sck_sync_reg[1];
   assign byte_in  = {shift_reg[6:0], si_sync_reg[1]};
   // sampling only when not paused, so held clocks never advance the sequence
   assign byte_done = sel_act & ~paused_reg & sck_rise & (bit_cnt_reg == 3'h7);
   assign so_oe_n_out = ~(sel_act & ~paused_reg & (state_reg == ST_RDATA));

   // flags register is always writable, others need time-set
   assign reg_wr_ok = (addr_reg == `SRC_FLAGS_ADDR) | time_set_out;
   assign fifo_push = byte_done & (state_reg == ST_WDATA) & reg_wr_ok;
   assign fifo_full_out = ~fifo_ready;

   src_fifo #(
      .WIDTH (12),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_fifo (
      .core_clk_in  (core_clk_in),
      .reset_in     (reset_in),
      .clk_en_in    (clk_en_in),
      .wr_valid_in  (fifo_push),
      .wr_ready_out (fifo_ready),
      .wr_data_in   ({addr_reg, byte_in}),
      .rd_valid_out (fifo_out_valid),
      .rd_ready_in  (wr_ready_in),
      .rd_data_out  (fifo_out_data)
   );
   assign wr_valid_out = fifo_out_valid;
   assign wr_addr_out  = fifo_out_data[11:8];
   assign wr_data_out  = fifo_out_data[7:0];

   // pin synchronisers; first stage read only by the second
   always @(posedge core_clk_in) begin
      if (reset_in) begin
         sel_sync_reg   <= 3'h7;
         sck_sync_reg   <= 3'h0;
         si_sync_reg    <= 2'h0;
         pause_sync_reg <= 2'h3;
      end else if (clk_en_in) begin
         sel_sync_reg   <= {sel_sync_reg[1:0], sel_n_in};
         sck_sync_reg   <= {sck_sync_reg[1:0], sck_in};
         si_sync_reg    <= {si_sync_reg[0], si_in};
         pause_sync_reg <= {pause_sync_reg[0], pause_n_in};
      end
   end

   // pause only changes while the serial clock is low, and clears whenever select is released
   always @(posedge core_clk_in) begin
      if (reset_in)
         paused_reg <= 1'b0;
      else if (clk_en_in) begin
         if (!sel_act)
            paused_reg <= 1'b0;
         else if (sck_low)
            paused_reg <= ~pause_sync_reg[1];
      end
   end

   always @(posedge core_clk_in) begin
      if (clk_en_in)
         rd_byte_reg <= clock_regs[addr_reg];
   end

   always @(posedge core_clk_in) begin
      if (reset_in) begin
         state_reg         <= ST_OPCODE;
         bit_cnt_reg       <= 3'h0;
         shift_reg         <= 8'h00;
         opcode_reg        <= 8'h00;
         addr_reg          <= 4'h0;
         out_reg           <= 8'h00;
         so_out            <= 1'b0;
         wrote_reg         <= 1'b0;
         write_latch_out   <= 1'b0;
         auto_save_en_out  <= 1'b1;
         save_req_out      <= 1'b0;
         reload_req_out    <= 1'b0;
         time_load_out     <= 1'b0;
         snapshot_lock_out <= 1'b0;
         time_set_out      <= 1'b0;
      end else if (clk_en_in) begin
         save_req_out   <= 1'b0;
         reload_req_out <= 1'b0;
         time_load_out  <= 1'b0;
         if (sel_fall) begin
            state_reg   <= ST_OPCODE;
            bit_cnt_reg <= 3'h0;
            wrote_reg   <= 1'b0;
         end
         if (sel_rise) begin
            // commands take effect at select release
            if (state_reg == ST_SPECIAL) begin
               write_latch_out <= 1'b0;
               case (opcode_reg)
                  `SRC_OP_SAVE:     save_req_out     <= 1'b1;
                  `SRC_OP_RELOAD:   reload_req_out   <= 1'b1;
                  `SRC_OP_AUTO_ON:  auto_save_en_out <= 1'b1;
                  `SRC_OP_AUTO_OFF: auto_save_en_out <= 1'b0;
                  default:          save_req_out     <= 1'b0;
               endcase
            end else if (state_reg == ST_WDATA && wrote_reg)
               write_latch_out <= 1'b0;
            else if (state_reg == ST_IGNORE && opcode_reg == `SRC_OP_SET_LATCH)
               write_latch_out <= 1'b1;
            else if (state_reg == ST_IGNORE && opcode_reg == `SRC_OP_CLEAR_LATCH)
               write_latch_out <= 1'b0;
            state_reg <= ST_IGNORE;
         end else if (sel_act && !paused_reg && !sel_fall) begin
            if (sck_rise) begin
               shift_reg   <= byte_in;
               bit_cnt_reg <= bit_cnt_reg + 3'h1;
            end
            // output stage: load byte at start, shift on falling edge
            if (state_reg == ST_RDATA && sck_fall) begin
               so_out  <= out_reg[7];
               out_reg <= {out_reg[6:0], 1'b0};
               if (bit_cnt_reg == 3'h0)
                  out_reg <= {rd_byte_reg[6:0], 1'b0};
               if (bit_cnt_reg == 3'h0)
                  so_out <= rd_byte_reg[7];
            end
            if (byte_done) begin
               case (state_reg)
                  ST_OPCODE: begin
                     opcode_reg <= byte_in;
                     case (byte_in)
                        `SRC_OP_CLOCK_READ:
                           state_reg <= nv_busy_in ? ST_IGNORE : ST_ADDR;
                        `SRC_OP_CLOCK_WRITE:
                           state_reg <= (write_latch_out && !nv_busy_in) ?
                                        ST_ADDR : ST_IGNORE;
                        `SRC_OP_SAVE, `SRC_OP_RELOAD, `SRC_OP_AUTO_ON, `SRC_OP_AUTO_OFF:
                           state_reg <= write_latch_out ? ST_SPECIAL : ST_IGNORE;
                        default:
                           state_reg <= ST_IGNORE;
                     endcase
                  end
                  ST_ADDR: begin
                     addr_reg  <= byte_in[3:0];
                     state_reg <= (opcode_reg == `SRC_OP_CLOCK_READ) ? ST_RDATA : ST_WDATA;
                  end
                  ST_RDATA: begin
                     addr_reg <= addr_reg + 4'h1;
                  end
                  ST_WDATA: begin
                     wrote_reg <= 1'b1;
                     if (reg_wr_ok)
                        clock_regs[addr_reg] <= byte_in;
                     if (addr_reg == `SRC_FLAGS_ADDR) begin
                        snapshot_lock_out <= byte_in[`SRC_FLAGS_SNAP_BIT];
                        time_set_out      <= byte_in[`SRC_FLAGS_TSET_BIT];
                        if (time_set_out && !byte_in[`SRC_FLAGS_TSET_BIT])
                           time_load_out <= 1'b1;
                     end
                     addr_reg <= addr_reg + 4'h1;
                  end
                  default:
                     state_reg <= state_reg;
               endcase
            end
         end
      end
   end
endmodule // src_spi_clock_nv

// >>> src_spi_clock_nv_props.sv
`timescale 1ns/100ps
module src_spi_clock_nv_props (
   input wire       core_clk_in,
   input wire       reset_in,
   input wire       sel_n_in,
   input wire       pause_n_in,
   input wire       so_oe_n_out,
   input wire       save_req_out,
   input wire       reload_req_out,
   input wire       auto_save_en_out,
   input wire       write_latch_out,
   input wire       time_load_out,
   input wire       time_set_out,
   input wire       wr_valid_out,
   input wire       wr_ready_in,
   input wire [3:0] wr_addr_out,
   input wire [7:0] wr_data_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (reset_in);
   // reset checks keyed on release, since the disable hides the reset cycles
   AST_RST_LATCH: assert property ($fell(reset_in) |-> !write_latch_out && auto_save_en_out)
      else $error("latch or auto-save wrong after reset");
   AST_RST_PINS: assert property ($fell(reset_in) |-> so_oe_n_out && !save_req_out)
      else $error("outputs wrong after reset");
   AST_SAVE_ONE: assert property (save_req_out |=> !save_req_out)
      else $error("save request longer than one cycle");
   AST_RELOAD_ONE: assert property (reload_req_out |=> !reload_req_out)
      else $error("reload request longer than one cycle");
   AST_REQ_RELEASE: assert property ((save_req_out || reload_req_out)
      |-> sel_n_in ##[0:2] !write_latch_out)
      else $error("request without select release or latch kept");
   AST_IDLE_FLOAT: assert property (sel_n_in [*4] |-> so_oe_n_out)
      else $error("output driven while deselected");
   AST_PAUSE_FLOAT: assert property (!pause_n_in [*5] |-> so_oe_n_out)
      else $error("output driven while paused");
   AST_TIME_LOAD: assert property ($fell(time_set_out) |-> ##[0:2] time_load_out)
      else $error("no counter load after time-set cleared");
   AST_FIFO_HOLD: assert property (wr_valid_out && !wr_ready_in
      |=> wr_valid_out && $stable({wr_addr_out, wr_data_out}))
      else $error("queued write changed while stalled");
endmodule // src_spi_clock_nv_props
bind src_spi_clock_nv src_spi_clock_nv_props chk_i (.core_clk_in, .reset_in, .sel_n_in,
   .pause_n_in, .so_oe_n_out, .save_req_out, .reload_req_out, .auto_save_en_out,
   .write_latch_out, .time_load_out, .time_set_out, .wr_valid_out, .wr_ready_in,
   .wr_addr_out, .wr_data_out);

// >>> src_spi_master.sv
`timescale 1ns/100ps
module src_spi_master (
   input  wire  clk_in,
   input  wire  so_in,
   input  wire  so_oe_n_in,
   output logic sel_n_out,
   output logic sck_out,
   output logic si_out,
   output logic pause_n_out
);
   initial {sel_n_out, sck_out, si_out, pause_n_out} = 4'b1001;
   task sel(input logic low);
      @(negedge clk_in);
      sel_n_out = !low;
      #400;
   endtask
   // 400 ns period, far below the read limit
   task xb(input logic [7:0] t, output logic [7:0] r);
      r = 8'h00;
      for (int i = 7; i >= 0; i--) begin
         si_out = t[i];
         #200 sck_out = 1'b1;
         // sampled late: output moves some cycles after the fall
         #195 r = {r[6:0], so_oe_n_in ? ~r[0] : so_in};
         #5 sck_out = 1'b0;
      end
   endtask
   task hold_on(input int n);
      #300 pause_n_out = 1'b0;
      repeat (n) #200 sck_out = ~sck_out;
      #200;
   endtask
   task hold_off;
      pause_n_out = 1'b1;
      #400;
   endtask
endmodule // src_spi_master

// >>> src_spi_clock_nv_bench.sv
`timescale 1ns/100ps
`include "src_defs.vh"
module src_spi_clock_nv_bench;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        busy = 1'b0;
   logic        rdy = 1'b1;
   logic        en = 1'b1;
   wire         sel_n, sck, si, pause_n, so, so_oe_n, sv, rl, ase, wl, tl, snap, ts, wv, full;
   wire  [3:0]  wa;
   wire  [7:0]  wd;
   int          mismatches = 0;
   int          samples_checked = 0;
   int          sv_c = 0, rl_c = 0, tl_c = 0, oe_c = 0, s0, r0;
   logic [7:0]  got[$];
   logic [3:0]  pops[$];
   logic [7:0]  popd[$];
   logic [7:0]  r;
   logic [10:0] rows[4] = '{{`SRC_OP_SAVE, 3'b101}, {`SRC_OP_RELOAD, 3'b011},
      {`SRC_OP_AUTO_OFF, 3'b000}, {`SRC_OP_AUTO_ON, 3'b001}};
   src_spi_clock_nv uut (.core_clk_in(clk), .reset_in(rst), .clk_en_in(en), .sel_n_in(sel_n),
      .sck_in(sck), .si_in(si), .pause_n_in(pause_n), .so_out(so), .so_oe_n_out(so_oe_n),
      .nv_busy_in(busy), .save_req_out(sv), .reload_req_out(rl), .auto_save_en_out(ase),
      .write_latch_out(wl), .time_load_out(tl), .snapshot_lock_out(snap), .time_set_out(ts),
      .wr_valid_out(wv), .wr_ready_in(rdy), .wr_addr_out(wa), .wr_data_out(wd),
      .fifo_full_out(full));
   src_spi_master m (.clk_in(clk), .so_in(so), .so_oe_n_in(so_oe_n), .sel_n_out(sel_n),
      .sck_out(sck), .si_out(si), .pause_n_out(pause_n));
   initial forever #25 clk = ~clk;
   // pulses last one cycle, so count them rather than poll
   always @(posedge clk) begin
      sv_c += int'(sv === 1'b1);
      rl_c += int'(rl === 1'b1);
      tl_c += int'(tl === 1'b1);
      oe_c += int'(so_oe_n === 1'b0);
      if (wv === 1'b1 && rdy) begin
         pops.push_back(wa);
         popd.push_back(wd);
      end
   end
   task chk(input logic [11:0] seen, input logic [11:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task cmd(input logic [7:0] op, input logic [7:0] a, input int n, input logic [7:0] d);
      logic [7:0] rb;
      m.sel(1);
      m.xb(op, rb);
      if (n >= 0) m.xb(a, rb);
      for (int i = 0; i < n; i++) begin
         m.xb(d, rb);
         got.push_back(rb);
      end
      m.sel(0);
   endtask
   task we;
      cmd(`SRC_OP_SET_LATCH, 8'h00, -1, 8'h00);
   endtask
   initial begin
      repeat (5) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      chk(wl, 0);
      chk(ase, 1);
      chk(so_oe_n, 1);
      // enable low must freeze the command path
      en = 1'b0;
      we;
      chk(wl, 0);
      en = 1'b1;
      for (int k = 0; k < 4; k++) begin
         s0 = sv_c;
         r0 = rl_c;
         we;
         chk(wl, 1);
         cmd(rows[k][10:3], 8'h00, -1, 8'h00);
         chk(12'(sv_c - s0), rows[k][2]);
         chk(12'(rl_c - r0), rows[k][1]);
         chk(ase, rows[k][0]);
         chk(wl, 0);
      end
      s0 = sv_c;
      cmd(`SRC_OP_SAVE, 8'h00, -1, 8'h00);
      chk(12'(sv_c - s0), 0);
      busy = 1'b1;
      s0 = oe_c;
      cmd(`SRC_OP_CLOCK_READ, 8'h00, 1, 8'h00);
      we;
      cmd(`SRC_OP_CLOCK_WRITE, 8'h00, 1, 8'h01);
      chk(12'(oe_c - s0), 0);
      chk(ts, 0);
      chk(wl, 1);
      busy = 1'b0;
      // refused write leaves the latch set, so drop it on purpose
      cmd(`SRC_OP_CLEAR_LATCH, 8'h00, -1, 8'h00);
      chk(wl, 0);
      cmd(`SRC_OP_CLOCK_WRITE, 8'h00, 1, 8'h02);
      chk(snap, 0);
      we;
      cmd(`SRC_OP_CLOCK_WRITE, 8'h00, 1, 8'h01);
      chk(ts, 1);
      chk(wl, 0);
      rdy = 1'b0;
      pops.delete();
      popd.delete();
      we;
      cmd(`SRC_OP_CLOCK_WRITE, 8'h01, 18, 8'hA5);
      chk(full, 1);
      rdy = 1'b1;
      repeat (40) @(negedge clk);
      chk(12'(pops.size()), 16);
      for (int i = 0; i < 16; i++) chk(pops[i], 12'((i + 1) % 16));
      for (int i = 0; i < 16; i++) chk(popd[i], 8'hA5);
      we;
      cmd(`SRC_OP_CLOCK_WRITE, 8'h00, 1, 8'h03);
      chk(snap, 1);
      got.delete();
      cmd(`SRC_OP_CLOCK_READ, 8'h0E, 3, 8'h00);
      chk(got[0], 8'hA5);
      chk(got[1], 8'hA5);
      chk(got[2], 8'h03);
      m.sel(1);
      m.xb(`SRC_OP_CLOCK_READ, r);
      m.xb(8'h0F, r);
      m.hold_on(4);
      chk(so_oe_n, 1);
      m.hold_off;
      m.xb(8'hFF, r);
      m.sel(0);
      chk(r, 8'hA5);
      we;
      cmd(`SRC_OP_CLOCK_WRITE, 8'h00, 1, 8'h01);
      chk(snap, 0);
      chk(ts, 1);
      s0 = tl_c;
      we;
      cmd(`SRC_OP_CLOCK_WRITE, 8'h00, 1, 8'h02);
      chk(12'(tl_c - s0), 1);
      chk(snap, 1);
      s0 = pops.size();
      we;
      cmd(`SRC_OP_CLOCK_WRITE, 8'h03, 1, 8'hA5);
      chk(12'(pops.size() - s0), 0);
      we;
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      chk(wl, 0);
      chk(snap, 0);
      report_and_stop;
   end
   initial begin
      #1000000;
      mismatches++;
      report_and_stop;
   end
endmodule // src_spi_clock_nv_bench
